// >>> core/cmx_regs.sv
// Comparator mode, input-select and edge-flag register bank.
// Assumes a single-cycle special-function register bus from the core
// and a synchronous comparator output level.
//
// Functional notes
// - Bit 5 of mode enables rising interrupt
// - Bit 4 of mode enables falling interrupt
// - Mode bits 7:6 and 3:2 read zero
// - Mode bits 1:0 set comparator response speed
// - Mux upper nibble picks negative input pin
// - Mux lower nibble picks positive input pin
// - Edge flags set on output transitions
// - Edge flags stay set until software clears
`timescale 1ns/1ps
`include "cmx_consts.svh"

module cmx_regs
    import cmx_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // Comparator side
    input wire logic cmp_out_i,
    output logic [1:0] response_speed_sel_o,
    output logic [9:0] neg_pin_en_o,
    output logic [9:0] pos_pin_en_o,
    // Interrupt request
    output logic cmp_irq_o
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    // One-hot pin enable for a select code; none above the last pin
    function automatic cmx_pins_t sel_decode(input logic [3:0] code);
        cmx_pins_t pins;
        pins = '0;
        if (code <= `CMX_SEL_LAST) begin
            pins[code] = 1'b1;
        end
        return pins;
    endfunction : sel_decode

    cmx_state_t st_q;
    cmx_state_t st_d;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_mux;
    logic [7:0] mode_rd;
    logic [7:0] ctrl_rd;
    logic [7:0] mux_rd;

    // Reset bytes, sliced into their fields at reset
    localparam logic [7:0] mode_rst_val = `CMX_MODE_RST;
    localparam logic [7:0] mux_rst_val = `CMX_MUX_RST;

    // ************************************************************
    // Edge detection
    // ************************************************************
    cmx_edge_if edge_bus ();

    cmx_edge_det u_edge (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .cmp_out_i(cmp_out_i),
        .edge_o(edge_bus.det)
    );

    // Write strobes per register
    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `CMX_ADDR_CTRL);
    assign wr_mode = sfr_wr_i && (sfr_addr_i == `CMX_ADDR_MODE);
    assign wr_mux = sfr_wr_i && (sfr_addr_i == `CMX_ADDR_MUX);

    // Read views; unused bits forced to zero
    always_comb begin
        mode_rd = `CMX_BYTE_ZERO;
        mode_rd[`CMX_BIT_RIE] = st_q.rise_irq_enable;
        mode_rd[`CMX_BIT_FIE] = st_q.fall_irq_enable;
        mode_rd[`CMX_SPD_HI:`CMX_SPD_LO] = st_q.response_speed_sel;
        ctrl_rd = `CMX_BYTE_ZERO;
        ctrl_rd[`CMX_BIT_RIF] = st_q.rise_edge_flag;
        ctrl_rd[`CMX_BIT_FIF] = st_q.fall_edge_flag;
        mux_rd = {st_q.neg_input_sel, st_q.pos_input_sel};
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        // Mode register; only enables and speed are stored
        if (wr_mode) begin
            st_d.rise_irq_enable = sfr_wdata_i[`CMX_BIT_RIE];
            st_d.fall_irq_enable = sfr_wdata_i[`CMX_BIT_FIE];
            st_d.response_speed_sel =
                cmx_speed_t'(sfr_wdata_i[`CMX_SPD_HI:`CMX_SPD_LO]);
        end
        // Input select register
        if (wr_mux) begin
            st_d.neg_input_sel = sfr_wdata_i[`CMX_NEG_HI:`CMX_NEG_LO];
            st_d.pos_input_sel = sfr_wdata_i[`CMX_POS_HI:`CMX_POS_LO];
        end
        // Flags: software write, then a new edge wins
        if (wr_ctrl) begin
            st_d.rise_edge_flag = sfr_wdata_i[`CMX_BIT_RIF];
            st_d.fall_edge_flag = sfr_wdata_i[`CMX_BIT_FIF];
        end
        if (edge_bus.rise) begin
            st_d.rise_edge_flag = 1'b1;
        end
        if (edge_bus.fall) begin
            st_d.fall_edge_flag = 1'b1;
        end
        // Interrupt follows the next flag and enable values
        st_d.irq = (st_d.rise_edge_flag && st_d.rise_irq_enable) ||
                   (st_d.fall_edge_flag && st_d.fall_irq_enable);
        // Pin enables; unmapped codes connect nothing
        st_d.neg_pins = sel_decode(st_d.neg_input_sel);
        st_d.pos_pins = sel_decode(st_d.pos_input_sel);
        // Registered read data, zero on unmapped address
        st_d.rdata = `CMX_BYTE_ZERO;
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                `CMX_ADDR_CTRL: st_d.rdata = ctrl_rd;
                `CMX_ADDR_MODE: st_d.rdata = mode_rd;
                `CMX_ADDR_MUX: st_d.rdata = mux_rd;
                default: st_d.rdata = `CMX_BYTE_ZERO;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q.rise_irq_enable <= mode_rst_val[`CMX_BIT_RIE];
            st_q.fall_irq_enable <= mode_rst_val[`CMX_BIT_FIE];
            st_q.response_speed_sel <=
                cmx_speed_t'(mode_rst_val[`CMX_SPD_HI:`CMX_SPD_LO]);
            st_q.neg_input_sel <= mux_rst_val[`CMX_NEG_HI:`CMX_NEG_LO];
            st_q.pos_input_sel <= mux_rst_val[`CMX_POS_HI:`CMX_POS_LO];
            st_q.rise_edge_flag <= `CMX_FLAG_RST;
            st_q.fall_edge_flag <= `CMX_FLAG_RST;
            st_q.irq <= 1'b0;
            st_q.neg_pins <= '0;
            st_q.pos_pins <= '0;
            st_q.rdata <= `CMX_BYTE_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flops
    assign sfr_rdata_o = st_q.rdata;
    assign response_speed_sel_o = st_q.response_speed_sel;
    assign neg_pin_en_o = st_q.neg_pins;
    assign pos_pin_en_o = st_q.pos_pins;
    assign cmp_irq_o = st_q.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_mode_rie_write: assert property (
        wr_mode |=> (st_q.rise_irq_enable == $past(sfr_wdata_i[5])))
        else $error("rise enable not stored");

    a_mode_fie_write: assert property (
        wr_mode |=> (st_q.fall_irq_enable == $past(sfr_wdata_i[4])))
        else $error("fall enable not stored");

    a_mode_unused_zero: assert property (
        (sfr_rd_i && sfr_addr_i == `CMX_ADDR_MODE)
            |=> (sfr_rdata_o[7:6] == 2'h0 && sfr_rdata_o[3:2] == 2'h0))
        else $error("unused mode bits read nonzero");

    a_speed_follows: assert property (
        wr_mode |=> (response_speed_sel_o == $past(sfr_wdata_i[1:0])))
        else $error("speed output wrong after write");

    a_neg_pin_map: assert property (
        (wr_mux && sfr_wdata_i[`CMX_NEG_HI:`CMX_NEG_LO] <= `CMX_SEL_LAST)
            |=> neg_pin_en_o[$past(sfr_wdata_i[`CMX_NEG_HI:`CMX_NEG_LO])])
        else $error("negative pin not selected");

    a_pos_pin_map: assert property (
        (wr_mux && sfr_wdata_i[`CMX_POS_HI:`CMX_POS_LO] <= `CMX_SEL_LAST)
            |=> pos_pin_en_o[$past(sfr_wdata_i[`CMX_POS_HI:`CMX_POS_LO])])
        else $error("positive pin not selected");

    a_none_code: assert property (
        (wr_mux && sfr_wdata_i[`CMX_POS_HI:`CMX_POS_LO] > `CMX_SEL_LAST)
            |=> (pos_pin_en_o == '0))
        else $error("pin connected for none code");

    a_none_neg: assert property (
        (wr_mux && sfr_wdata_i[`CMX_NEG_HI:`CMX_NEG_LO] > `CMX_SEL_LAST)
            |=> (neg_pin_en_o == '0))
        else $error("negative pin connected for none code");

    a_rise_sets: assert property (
        ($rose(cmp_out_i) && $past(u_edge.st_q.armed)) |=> st_q.rise_edge_flag)
        else $error("rise flag missed edge");

    a_flag_sticky: assert property (
        (st_q.fall_edge_flag && !wr_ctrl) |=> st_q.fall_edge_flag)
        else $error("fall flag cleared by hardware");

    a_irq_cause: assert property (
        cmp_irq_o == ((st_q.rise_edge_flag && st_q.rise_irq_enable) ||
                      (st_q.fall_edge_flag && st_q.fall_irq_enable)))
        else $error("interrupt does not match flags");

    c_rise_irq: cover property (edge_bus.rise && st_q.rise_irq_enable
        ##1 cmp_irq_o);
    c_fall_irq: cover property (edge_bus.fall && st_q.fall_irq_enable
        ##1 cmp_irq_o);
    c_set_beats_clear: cover property (wr_ctrl && edge_bus.rise);
    c_none_sel: cover property (wr_mux && sfr_wdata_i == 8'hff);

endmodule : cmx_regs

// >>> core/cmx_consts.svh
// Constants of the comparator mode and input-select register bank.
// Assumes inclusion by bare name from the package and design modules.
`ifndef CMX_CONSTS_SVH
`define CMX_CONSTS_SVH

// ************************************************************
// Register addresses on the special-function register bus
// ************************************************************
`define CMX_ADDR_CTRL 8'h9b
`define CMX_ADDR_MODE 8'h9d
`define CMX_ADDR_MUX 8'h9f

// ************************************************************
// Reset values
// ************************************************************
`define CMX_MODE_RST 8'h02
`define CMX_MUX_RST 8'hff
`define CMX_FLAG_RST 1'h0

// ************************************************************
// Field positions
// ************************************************************
`define CMX_BIT_RIE 5
`define CMX_BIT_FIE 4
`define CMX_BIT_RIF 5
`define CMX_BIT_FIF 4
`define CMX_SPD_HI 1
`define CMX_SPD_LO 0
`define CMX_NEG_HI 7
`define CMX_NEG_LO 4
`define CMX_POS_HI 3
`define CMX_POS_LO 0

// ************************************************************
// Select decoding
// ************************************************************
`define CMX_NUM_PINS 10
`define CMX_SEL_LAST 4'h9
`define CMX_BYTE_ZERO 8'h00

`endif

// >>> core/cmx_pkg.sv
// Types shared by the comparator register bank modules.
// Assumes the constants header sits beside it in core/.
`include "cmx_consts.svh"

package cmx_pkg;

    // ************************************************************
    // Response speed codes (00 fastest, 11 slowest and lowest power)
    // ************************************************************
    typedef enum logic [1:0] {
        CMX_SPD_FAST = 2'h0,
        CMX_SPD_MID1 = 2'h1,
        CMX_SPD_MID2 = 2'h2,
        CMX_SPD_SLOW = 2'h3
    } cmx_speed_t;

    // One-hot pin enables; bit k is code k of a select nibble
    typedef logic [`CMX_NUM_PINS-1:0] cmx_pins_t;

    // ************************************************************
    // Register bank state
    // ************************************************************
    typedef struct packed {
        logic rise_irq_enable;
        logic fall_irq_enable;
        cmx_speed_t response_speed_sel;
        logic [3:0] neg_input_sel;
        logic [3:0] pos_input_sel;
        logic rise_edge_flag;
        logic fall_edge_flag;
        logic irq;
        cmx_pins_t neg_pins;
        cmx_pins_t pos_pins;
        logic [7:0] rdata;
    } cmx_state_t;

    // Edge detector state
    typedef struct packed {
        logic prev;
        logic armed;
    } cmx_edge_state_t;

endpackage : cmx_pkg

// >>> core/cmx_edge_if.sv
// Edge events passed from the detector to the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface cmx_edge_if;
    logic rise;
    logic fall;

    // Detector drives, register bank listens
    modport det (output rise, output fall);
    modport bank (input rise, input fall);
endinterface : cmx_edge_if

// >>> core/cmx_edge_det.sv
// Edge detector on the comparator output level.
// Assumes the comparator level is already synchronous to the clock.
`timescale 1ns/1ps

module cmx_edge_det
    import cmx_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Comparator level
    input wire logic cmp_out_i,
    // Edge events
    cmx_edge_if.det edge_o
);

    cmx_edge_state_t st_q;
    cmx_edge_state_t st_d;

    // ************************************************************
    // Next state: remember the level, arm after first sample
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.prev = cmp_out_i;
        st_d.armed = 1'b1;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // One-cycle pulses; no edge until one level has been seen
    assign edge_o.rise = st_q.armed & cmp_out_i & ~st_q.prev;
    assign edge_o.fall = st_q.armed & ~cmp_out_i & st_q.prev;

endmodule : cmx_edge_det

// >>> verification/cmx_cmp_model.sv
// Behavioural comparator and input multiplexer beside the bank.
// Assumes one clock shared with the register bank.
`timescale 1ns/1ps

module cmx_cmp_model
    import cmx_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Analog side: high while the positive pin is above the negative
    input wire logic pos_above_i,
    // Settings from the bank
    input wire logic [1:0] speed_i,
    input wire logic [9:0] neg_en_i,
    input wire logic [9:0] pos_en_i,
    // Latched comparator output
    output logic cmp_out_o
);
    logic raw;
    logic stage_q;

    // Output low unless both inputs have a pin
    assign raw = (|neg_en_i) && (|pos_en_i) && pos_above_i;

    // Slow modes answer one cycle later
    always_ff @(posedge ref_clk_i) begin
        stage_q <= raw;
        cmp_out_o <= speed_i[1] ? stage_q : raw;
    end
endmodule : cmx_cmp_model

// >>> verification/cmx_regs_tb.sv
// Self-checking bench for the comparator register bank.
// Assumes the core/ files and the comparator model compile first.
`timescale 1ns/1ps
`include "cmx_consts.svh"

module cmx_regs_tb
    import cmx_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic cmp_out;
    logic pos_above = 1'b0;
    logic [1:0] speed;
    logic [9:0] neg_en;
    logic [9:0] pos_en;
    logic irq;
    logic [7:0] v;
    int fail_count = 0;
    int checks_done = 0;

    cmx_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr_s), .sfr_wdata_i(wdata), .sfr_rd_i(rd_s),
        .sfr_rdata_o(rdata), .cmp_out_i(cmp_out),
        .response_speed_sel_o(speed), .neg_pin_en_o(neg_en),
        .pos_pin_en_o(pos_en), .cmp_irq_o(irq));
    cmx_cmp_model model (.ref_clk_i(ref_clk_i), .pos_above_i(pos_above),
        .speed_i(speed), .neg_en_i(neg_en), .pos_en_i(pos_en),
        .cmp_out_o(cmp_out));

    // ****
    // Shared tasks
    // ****
    task automatic check(input string what, input logic [9:0] exp,
        input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(posedge ref_clk_i);
        #1;
        wr_s = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd_s = 1'b1;
        @(posedge ref_clk_i);
        #1;
        rd_s = 1'b0;
        d = rdata;
        @(posedge ref_clk_i);
        #1;
    endtask : rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd(`CMX_ADDR_MODE, v);
        check("mode", 10'h002, {2'h0, v});
        check("rdata idle", 10'h000, {2'h0, rdata});
        rd(`CMX_ADDR_MUX, v);
        check("mux", 10'h0ff, {2'h0, v});
        check("speed", 10'h002, {8'h00, speed});
        check("neg pins", 10'h000, neg_en);
        check("pos pins", 10'h000, pos_en);
        check("irq", 10'h000, {9'h000, irq});
        $display("test reset done");
    endtask : t_reset

    task automatic t_mode();
        for (int i = 0; i < 4; i++) begin
            wr(`CMX_ADDR_MODE, 8'hfc | 8'(i));
            rd(`CMX_ADDR_MODE, v);
            check("mode", 10'h030 | 10'(i), {2'h0, v});
            check("speed", 10'(i), {8'h00, speed});
        end
        wr(`CMX_ADDR_MODE, 8'h00);
        wr(8'h9e, 8'hff);
        rd(8'h9e, v);
        check("unmapped", 10'h000, {2'h0, v});
        rd(`CMX_ADDR_MODE, v);
        check("mode", 10'h000, {2'h0, v});
        $display("test mode done");
    endtask : t_mode

    task automatic t_mux();
        logic [3:0] n;
        logic [9:0] e;
        for (int c = 0; c < 16; c++) begin
            n = c[3:0];
            wr(`CMX_ADDR_MUX, {n, ~n});
            rd(`CMX_ADDR_MUX, v);
            check("mux", {2'h0, n, ~n}, {2'h0, v});
            e = (n < 4'ha) ? 10'h001 << n : 10'h000;
            check("neg pins", e, neg_en);
            e = (~n < 4'ha) ? 10'h001 << ~n : 10'h000;
            check("pos pins", e, pos_en);
        end
        wr(`CMX_ADDR_MUX, 8'hff);
        check("neg pins", 10'h000, neg_en);
        check("pos pins", 10'h000, pos_en);
        $display("test mux done");
    endtask : t_mux

    task automatic t_edges();
        wr(`CMX_ADDR_MUX, 8'h00);
        wr(`CMX_ADDR_CTRL, 8'h00);
        wr(`CMX_ADDR_MODE, 8'h20);
        pos_above = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        check("irq", 10'h001, {9'h000, irq});
        rd(`CMX_ADDR_CTRL, v);
        check("flags", 10'h020, {2'h0, v & 8'h30});
        pos_above = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        rd(`CMX_ADDR_CTRL, v);
        check("flags", 10'h030, {2'h0, v & 8'h30});
        wr(`CMX_ADDR_CTRL, 8'h00);
        check("irq", 10'h000, {9'h000, irq});
        wr(`CMX_ADDR_MODE, 8'h13);
        pos_above = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        check("irq", 10'h000, {9'h000, irq});
        pos_above = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        check("irq", 10'h001, {9'h000, irq});
        wr(`CMX_ADDR_MODE, 8'h00);
        check("irq", 10'h000, {9'h000, irq});
        repeat (20) @(posedge ref_clk_i);
        #1;
        rd(`CMX_ADDR_CTRL, v);
        check("flags", 10'h030, {2'h0, v & 8'h30});
        // Software clear lands on the same edge as a rising event
        wr(`CMX_ADDR_CTRL, 8'h00);
        pos_above = 1'b1;
        @(posedge ref_clk_i);
        #1;
        wr(`CMX_ADDR_CTRL, 8'h00);
        rd(`CMX_ADDR_CTRL, v);
        check("set wins", 10'h020, {2'h0, v & 8'h30});
        $display("test edges done");
    endtask : t_edges

    // ****
    // Clock, watchdog and main sequence
    // ****
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_mode();
        t_mux();
        t_edges();
        tally_and_finish();
    end
endmodule : cmx_regs_tb
